// ### rtl/tcs_timer.sv
// sixteen-bit timer/counter with gate, clock source select, prescaler and crystal driver
//
// Function
// - 16-bit up-counter read/written as two bytes; writes replace live count.
// - on-bit 0 stops; on-bit 1 counts, gated when gate-enable is 1.
// - source 00 instruction clock, 01 system clock, 10 pin or crystal, 11 reserved.
// - internal sources advance the count at prescaled multiples of system clock.
// - system-clock source advances four per instruction cycle.
// - external source counts rising edges while counting is enabled.
// - counter mode needs a falling edge before first counted rising edge.
// - prescale field divides the selected clock by 1, 2, 4 or 8.
// - prescale counter is hidden and cleared by any count byte write.
// - oscillator-enable starts the crystal driver; it runs through sleep.
// - sync-control bit set bypasses synchronisation of the external clock.
// - asynchronous external counting continues in sleep; overflow wakes processor.
// - mode switches between sync and async may drop or add one count.
// - rollover FFFFh to 0000h sets the overflow flag.
// - gated counting proceeds only while gate level equals gate polarity.
`timescale 1ns/100ps
module tcs_timer
  import tcs_pkg::*;
(
  input  wire logic       CLK_SYS,
  input  wire logic       RST,
  input  wire logic [2:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic       EXTERNAL_CLOCK_PIN,
  input  wire logic       CRYSTAL_IN_PIN,
  output logic            CRYSTAL_OUT_PIN,
  input  wire logic       GATE_PIN,
  input  wire logic       SLEEP,
  output logic            IRQ
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  tcs_ctrl_t   ctrl_r, ctrl_nxt;
  tcs_gate_t   gate_r, gate_nxt;
  logic [7:0]  status_r, status_nxt;
  logic [7:0]  mask_r, mask_nxt;
  logic [15:0] count_r, count_nxt;
  logic [7:0]  rdata_r, rdata_nxt;
  logic [1:0]  phase_r, phase_nxt;
  logic        ext_prev_r, ext_prev_nxt;
  logic        arm_r, arm_nxt;
  logic        pend_r, pend_nxt;
  logic        xout_r, xout_nxt;

  logic        pin_q, xtal_q, gate_q;
  logic        ext_level, ext_rise, ext_fall, ext_edge;
  logic        instr_tick;
  logic        src_tick;
  logic        gate_open;
  logic        run;
  logic        tick_gated;
  logic        inc;
  logic        cnt_wr;
  logic        ovf_ev;

  // register-write decode, used by several groups
  function automatic logic wr_hit(input logic we, input logic [2:0] a,
                                  input logic [2:0] target);
    wr_hit = we && (a == target);
  endfunction : wr_hit

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  tcs_sync u_sync_pin (
    .clk  (CLK_SYS),
    .rst  (RST),
    .d_in (EXTERNAL_CLOCK_PIN),
    .q    (pin_q)
  );

  tcs_sync u_sync_xtal (
    .clk  (CLK_SYS),
    .rst  (RST),
    .d_in (CRYSTAL_IN_PIN),
    .q    (xtal_q)
  );

  tcs_sync u_sync_gate (
    .clk  (CLK_SYS),
    .rst  (RST),
    .d_in (GATE_PIN),
    .q    (gate_q)
  );

  // ----------------------------------------------------------------
  // instruction clock: one-cycle enable every fourth system clock
  // ----------------------------------------------------------------
  assign instr_tick = (phase_r == INSTR_DIV_LAST);

  always_comb begin
    phase_nxt = 2'(phase_r + 2'h1);
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      phase_r <= 2'h0;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // ----------------------------------------------------------------
  // external source: edges, arming, synchronised hand-off
  // ----------------------------------------------------------------
  assign cnt_wr    = wr_hit(WR, ADDR, ADDR_CNT_LO) || wr_hit(WR, ADDR, ADDR_CNT_HI);
  assign ext_level = ctrl_r.oscillator_enable_bit ? xtal_q : pin_q;
  assign ext_rise  = ext_level && !ext_prev_r;
  assign ext_fall  = !ext_level && ext_prev_r;
  assign ext_edge  = ext_rise && arm_r;

  always_comb begin
    ext_prev_nxt = ext_level;
    arm_nxt      = arm_r;
    // a falling edge must come before the first counted rise
    if (cnt_wr || !ctrl_r.counter_on_bit) begin
      arm_nxt = 1'b0;
    end else if (ext_fall) begin
      arm_nxt = 1'b1;
    end
    // synchronous mode lands the edge on the next instruction clock
    pend_nxt = pend_r;
    if (instr_tick && !SLEEP) begin
      pend_nxt = 1'b0;
    end
    if (ext_edge && !ctrl_r.sync_control_bit) begin
      pend_nxt = 1'b1;
    end
    if (ctrl_r.sync_control_bit) begin
      pend_nxt = 1'b0;
    end
    // a write or a stop drops an edge still waiting for its tick
    if (cnt_wr || !ctrl_r.counter_on_bit) begin
      pend_nxt = 1'b0;
    end
    // driver pumps the crystal while its input reads low
    xout_nxt = ctrl_r.oscillator_enable_bit && !xtal_q;
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ext_prev_r <= 1'b0;
      arm_r      <= 1'b0;
      pend_r     <= 1'b0;
      xout_r     <= 1'b0;
    end else begin
      ext_prev_r <= ext_prev_nxt;
      arm_r      <= arm_nxt;
      pend_r     <= pend_nxt;
      xout_r     <= xout_nxt;
    end
  end

  assign CRYSTAL_OUT_PIN = xout_r;

  // ----------------------------------------------------------------
  // clock source select, enable and gate
  // ----------------------------------------------------------------
  always_comb begin
    case (ctrl_r.clock_source_field)
      CS_INSTR: src_tick = instr_tick && !SLEEP;
      CS_SYS:   src_tick = !SLEEP;
      CS_EXT: begin
        if (ctrl_r.sync_control_bit) begin
          src_tick = ext_edge;
        end else begin
          src_tick = pend_r && instr_tick && !SLEEP;
        end
      end
      CS_RSVD:  src_tick = 1'b0;
      default:  src_tick = 1'b0;
    endcase
  end

  // gate match: count when level equals polarity
  assign gate_open  = !gate_r.gate_enable_bit ||
                      (gate_q == gate_r.gate_polarity_bit);
  assign run        = ctrl_r.counter_on_bit && gate_open;
  // source ticks that survive the on bit and the gate
  assign tick_gated = src_tick && run;

  tcs_prescale u_prescale (
    .clk      (CLK_SYS),
    .rst      (RST),
    .clear    (cnt_wr),
    .tick_in  (tick_gated),
    .ratio    (ctrl_r.prescale_field),
    .tick_out (inc)
  );

  // ----------------------------------------------------------------
  // count register
  // ----------------------------------------------------------------
  // no rollover flag when a byte write lands in the same cycle
  assign ovf_ev = inc && !cnt_wr && (count_r == CNT_MAX);

  always_comb begin
    count_nxt = count_r;
    // a byte write wins over an increment in the same cycle
    if (cnt_wr) begin
      if (ADDR == ADDR_CNT_LO) begin
        count_nxt[7:0] = WDATA;
      end else begin
        count_nxt[15:8] = WDATA;
      end
    end else if (inc) begin
      count_nxt = 16'(count_r + 16'h0001);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      count_r <= CNT_RESET;
    end else begin
      count_r <= count_nxt;
    end
  end

  // ----------------------------------------------------------------
  // control, status and mask registers
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_nxt   = ctrl_r;
    gate_nxt   = gate_r;
    status_nxt = status_r;
    mask_nxt   = mask_r;
    // write masks keep reserved bits at zero
    if (wr_hit(WR, ADDR, ADDR_CTRL)) begin
      ctrl_nxt = tcs_ctrl_t'(WDATA & CTRL_WMASK);
    end
    if (wr_hit(WR, ADDR, ADDR_GATE)) begin
      gate_nxt = tcs_gate_t'(WDATA & GATE_WMASK);
    end
    if (wr_hit(WR, ADDR, ADDR_MASK)) begin
      mask_nxt = WDATA & STAT_WMASK;
    end
    if (wr_hit(WR, ADDR, ADDR_STATUS)) begin
      status_nxt = status_r & ~(WDATA & STAT_WMASK);
    end
    // set wins over a simultaneous clear
    if (ovf_ev) begin
      status_nxt[STAT_OVF_BIT] = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ctrl_r   <= tcs_ctrl_t'(CTRL_RESET);
      gate_r   <= tcs_gate_t'(GATE_RESET);
      status_r <= STAT_RESET;
      mask_r   <= MASK_RESET;
    end else begin
      ctrl_r   <= ctrl_nxt;
      gate_r   <= gate_nxt;
      status_r <= status_nxt;
      mask_r   <= mask_nxt;
    end
  end

  // level interrupt, also the wake request while sleeping
  assign IRQ = |(status_r & mask_r);

  // ----------------------------------------------------------------
  // read port: data valid only in the cycle after the strobe
  // ----------------------------------------------------------------
  always_comb begin
    rdata_nxt = 8'h00;
    // unmapped addresses read zero
    if (RD) begin
      case (ADDR)
        ADDR_CNT_LO: rdata_nxt = count_r[7:0];
        ADDR_CNT_HI: rdata_nxt = count_r[15:8];
        ADDR_CTRL:   rdata_nxt = ctrl_r;
        ADDR_GATE:   rdata_nxt = gate_r;
        ADDR_STATUS: rdata_nxt = status_r;
        ADDR_MASK:   rdata_nxt = mask_r;
        default:     rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign RDATA = rdata_r;

endmodule : tcs_timer

// ### rtl/tcs_pkg.sv
// shared constants and types of the sixteen-bit timer/counter
package tcs_pkg;

  // ----------------------------------------------------------------
  // register map (index on the 3-bit address port)
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_CNT_LO  = 3'h0;
  localparam logic [2:0] ADDR_CNT_HI  = 3'h1;
  localparam logic [2:0] ADDR_CTRL    = 3'h2;
  localparam logic [2:0] ADDR_GATE    = 3'h3;
  localparam logic [2:0] ADDR_STATUS  = 3'h4;
  localparam logic [2:0] ADDR_MASK    = 3'h5;

  // ----------------------------------------------------------------
  // field layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] clock_source_field;
    logic [1:0] prescale_field;
    logic       oscillator_enable_bit;
    logic       sync_control_bit;
    logic       rsvd;
    logic       counter_on_bit;
  } tcs_ctrl_t;

  typedef struct packed {
    logic       gate_enable_bit;
    logic       gate_polarity_bit;
    logic [5:0] rsvd;
  } tcs_gate_t;

  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [7:0] CTRL_WMASK   = 8'hFD;
  localparam logic [7:0] GATE_RESET   = 8'h00;
  localparam logic [7:0] GATE_WMASK   = 8'hC0;
  localparam logic [7:0] STAT_RESET   = 8'h00;
  localparam logic [7:0] STAT_WMASK   = 8'h01;
  localparam logic [7:0] MASK_RESET   = 8'h00;
  localparam int         STAT_OVF_BIT = 0;

  // ----------------------------------------------------------------
  // clock source codes
  // ----------------------------------------------------------------
  localparam logic [1:0] CS_INSTR = 2'h0;
  localparam logic [1:0] CS_SYS   = 2'h1;
  localparam logic [1:0] CS_EXT   = 2'h2;
  localparam logic [1:0] CS_RSVD  = 2'h3;

  // ----------------------------------------------------------------
  // counts
  // ----------------------------------------------------------------
  localparam logic [1:0]  INSTR_DIV_LAST = 2'h3;
  localparam logic [15:0] CNT_RESET      = 16'h0000;
  localparam logic [15:0] CNT_MAX        = 16'hFFFF;
  localparam logic [2:0]  PRE_RESET      = 3'h0;

endpackage : tcs_pkg

// ### rtl/tcs_sync.sv
// three-stage pin synchroniser that accepts a level once stages two and three agree
`timescale 1ns/100ps
module tcs_sync
  import tcs_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic d_in,
  output logic      q
);

  logic ff1_r, ff2_r, ff3_r, q_r;
  logic q_nxt;

  always_comb begin
    q_nxt = (ff2_r == ff3_r) ? ff3_r : q_r;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ff1_r <= 1'b0;
      ff2_r <= 1'b0;
      ff3_r <= 1'b0;
      q_r   <= 1'b0;
    end else begin
      ff1_r <= d_in;
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
      q_r   <= q_nxt;
    end
  end

  assign q = q_r;

endmodule : tcs_sync

// ### rtl/tcs_prescale.sv
// 2-bit selectable prescaler: divides a tick stream by 1, 2, 4 or 8
`timescale 1ns/100ps
module tcs_prescale
  import tcs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       clear,
  input  wire logic       tick_in,
  input  wire logic [1:0] ratio,
  output logic            tick_out
);

  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic [2:0] last;

  // terminal value of the divider for each ratio code
  function automatic logic [2:0] ratio_last(input logic [1:0] r);
    case (r)
      2'h0:    ratio_last = 3'h0;
      2'h1:    ratio_last = 3'h1;
      2'h2:    ratio_last = 3'h3;
      default: ratio_last = 3'h7;
    endcase
  endfunction : ratio_last

  always_comb begin
    last    = ratio_last(ratio);
    cnt_nxt = cnt_r;
    if (clear) begin
      cnt_nxt = PRE_RESET;
    end else if (tick_in) begin
      cnt_nxt = ((cnt_r & last) == last) ? PRE_RESET : 3'(cnt_r + 3'h1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= PRE_RESET;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign tick_out = tick_in && !clear && ((cnt_r & last) == last);

endmodule : tcs_prescale

// ### tb/tcs_src_model.sv
// far-side stand-in: external count clock and crystal
`timescale 1ns/100ps
module tcs_src_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ext_en,
  input  wire logic [3:0]  half,
  input  wire logic        xtal_drive,
  output logic             ext_pin,
  output logic             xtal_pin,
  output logic [15:0]      ext_rises,
  output logic [15:0]      xtal_rises
);
  logic [3:0] ph;
  logic [4:0] live;
  logic       tog;
  assign tog = ph >= half - 4'h1;
  always_ff @(posedge clk) begin
    if (rst) begin
      ph         <= 4'h0;
      live       <= 5'h00;
      ext_pin    <= 1'b0;
      xtal_pin   <= 1'b0;
      ext_rises  <= 16'h0000;
      xtal_rises <= 16'h0000;
    end else begin
      ph <= tog ? 4'h0 : ph + 4'h1;
      // crystal swings only while the driver keeps pumping it
      live <= xtal_drive ? 5'h1F : live - {4'h0, live != 5'h00};
      // each level holds a full half period, never a short pulse
      if (tog && (ext_en || ext_pin)) begin
        ext_pin   <= !ext_pin;
        ext_rises <= ext_rises + {15'h0, !ext_pin};
      end
      if (tog && live != 5'h00) begin
        xtal_pin   <= !xtal_pin;
        xtal_rises <= xtal_rises + {15'h0, !xtal_pin};
      end else if (live == 5'h00) begin
        xtal_pin <= 1'b0;
      end
    end
  end
endmodule : tcs_src_model

// ### tb/tcs_timer_sva.sv
// port-level checker of the timer/counter
`timescale 1ns/100ps
module tcs_timer_chk
  import tcs_pkg::*;
(
  input wire logic       CLK_SYS,
  input wire logic       RST,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic       CRYSTAL_OUT_PIN,
  input wire logic       IRQ
);
  logic on_r;
  logic mask_r;
  // shadows of the on bit and the mask bit
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      on_r   <= 1'b0;
      mask_r <= 1'b0;
    end else if (WR) begin
      if (ADDR == ADDR_CTRL) on_r <= WDATA[0];
      if (ADDR == ADDR_MASK) mask_r <= WDATA[0];
    end
  end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  rdata_idle_a: assert property (
    !$past(RD) |-> RDATA == 8'h00) else $error("read data set without a read");
  ctrl_rsvd_a: assert property (
    RD && ADDR == ADDR_CTRL |=> RDATA[1] == 1'b0) else $error("reserved bit reads one");
  cnt_write_a: assert property (
    WR && ADDR == ADDR_CNT_LO && !on_r ##1 !WR ##1 RD && ADDR == ADDR_CNT_LO
    |=> RDATA == $past(WDATA, 3)) else $error("count byte not replaced");
  cnt_hold_a: assert property (
    RD && ADDR == ADDR_CNT_LO && !on_r ##1 !WR ##1 RD && ADDR == ADDR_CNT_LO
    |=> RDATA == $past(RDATA, 2)) else $error("stopped count moved");
  irq_mask_a: assert property (
    !mask_r |-> !IRQ) else $error("masked interrupt raised");
  stat_irq_a: assert property (
    RD && ADDR == ADDR_STATUS && mask_r |=> RDATA[0] == $past(IRQ))
    else $error("status and interrupt disagree");
  irq_clear_a: assert property (
    WR && ADDR == ADDR_STATUS && WDATA[0] && !on_r |=> !IRQ) else $error("flag not cleared");
  xtal_off_a: assert property (
    WR && ADDR == ADDR_CTRL && !WDATA[3] |-> ##2 !CRYSTAL_OUT_PIN)
    else $error("crystal driven while disabled");
endmodule : tcs_timer_chk
bind tcs_timer tcs_timer_chk tcs_timer_chk_inst (
  .CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .CRYSTAL_OUT_PIN(CRYSTAL_OUT_PIN), .IRQ(IRQ));

// ### tb/test_tcs_timer.sv
// self-checking bench for the timer/counter
`timescale 1ns/100ps
`define CHK(g, e) begin \
  n_checks++; \
  if ((g) !== (e)) begin \
    err_total++; \
    $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); \
  end \
end
module test_tcs_timer
  import tcs_pkg::*;
;
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  gate;
    logic        pin;
    logic [15:0] exp;
  } tcs_row_t;
  // source, prescale, on bit and gate polarity against a 64-cycle run
  localparam tcs_row_t ROWS [12] = '{
    '{8'h41, 8'h00, 1'b0, 16'h0040}, '{8'h51, 8'h00, 1'b0, 16'h0020},
    '{8'h61, 8'h00, 1'b0, 16'h0010}, '{8'h71, 8'h00, 1'b0, 16'h0008},
    '{8'h01, 8'h00, 1'b0, 16'h0010}, '{8'h11, 8'h00, 1'b0, 16'h0008},
    '{8'hC1, 8'h00, 1'b0, 16'h0000}, '{8'h40, 8'h00, 1'b0, 16'h0000},
    '{8'h41, 8'hC0, 1'b0, 16'h0000}, '{8'h41, 8'hC0, 1'b1, 16'h0040},
    '{8'h41, 8'h80, 1'b0, 16'h0040}, '{8'h41, 8'h80, 1'b1, 16'h0000}};
  logic        CLK_SYS  = 1'b0;
  logic        RST      = 1'b1;
  logic [2:0]  ADDR     = 3'h0;
  logic [7:0]  WDATA    = 8'h00;
  logic        WR       = 1'b0;
  logic        RD       = 1'b0;
  logic        GATE_PIN = 1'b0;
  logic        SLEEP    = 1'b0;
  logic        ext_en   = 1'b0;
  logic [7:0]  RDATA, v;
  logic [15:0] c, d, r0, ext_rises, xtal_rises;
  logic        EXT, XIN, XOUT, IRQ, ok;
  int          err_total = 0;
  int          n_checks  = 0;
  always #12.5 CLK_SYS = ~CLK_SYS;
  tcs_timer tcs_timer_inst (
    .CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .EXTERNAL_CLOCK_PIN(EXT), .CRYSTAL_IN_PIN(XIN),
    .CRYSTAL_OUT_PIN(XOUT), .GATE_PIN(GATE_PIN), .SLEEP(SLEEP), .IRQ(IRQ));
  tcs_src_model tcs_src_model_inst (
    .clk(CLK_SYS), .rst(RST), .ext_en(ext_en), .half(4'h3), .xtal_drive(XOUT),
    .ext_pin(EXT), .xtal_pin(XIN), .ext_rises(ext_rises), .xtal_rises(xtal_rises));
  // ----
  // bus tasks and verdict
  // ----
  task automatic wr(input logic [2:0] a, input logic [7:0] dt);
    @(posedge CLK_SYS);
    ADDR  <= a;
    WDATA <= dt;
    WR    <= 1'b1;
    @(posedge CLK_SYS);
    WR    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] dt);
    @(posedge CLK_SYS);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLK_SYS);
    RD   <= 1'b0;
    #1 dt = RDATA;
  endtask : rd
  // high byte first so a low-byte read may follow the last write
  task automatic wcnt(input logic [15:0] cv);
    wr(ADDR_CNT_HI, cv[15:8]);
    wr(ADDR_CNT_LO, cv[7:0]);
  endtask : wcnt
  task automatic rdcnt(output logic [15:0] cv);
    rd(ADDR_CNT_LO, cv[7:0]);
    rd(ADDR_CNT_HI, cv[15:8]);
  endtask : rdcnt
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (30000) @(posedge CLK_SYS);
    err_total++;
    final_report();
  end
  initial begin
    repeat (12) @(posedge CLK_SYS);
    RST <= 1'b0;
    wr(3'h6, 8'hFF);
    wr(3'h7, 8'hFF);
    for (int i = 0; i < 8; i++) begin
      rd(i[2:0], v);
      `CHK(v, 8'h00)
    end
    `CHK(IRQ, 1'b0)
    $display("test reset done");
    wcnt(16'h3CA5);
    rd(ADDR_CNT_LO, v);
    rdcnt(c);
    `CHK(c, 16'h3CA5)
    wr(ADDR_CTRL, 8'hFF);
    rd(ADDR_CTRL, v);
    `CHK(v, 8'hFD)
    wr(ADDR_CTRL, 8'h00);
    rdcnt(c);
    `CHK(c, 16'h3CA5)
    $display("test access done");
    foreach (ROWS[i]) begin
      wr(ADDR_GATE, ROWS[i].gate);
      GATE_PIN <= ROWS[i].pin;
      wcnt(16'h0000);
      repeat (4) @(posedge CLK_SYS);
      wr(ADDR_CTRL, ROWS[i].ctrl);
      repeat (62) @(posedge CLK_SYS);
      wr(ADDR_CTRL, 8'h00);
      rdcnt(d);
      ok = d == ROWS[i].exp || (ROWS[i].exp != 16'h0000 &&
           (d == ROWS[i].exp - 16'h0001 || d == ROWS[i].exp + 16'h0001));
      `CHK(ok, 1'b1)
    end
    $display("test table done");
    // reset in mid-run with the count running and the flag raised
    wcnt(16'hFFFE);
    wr(ADDR_MASK, 8'h01);
    wr(ADDR_CTRL, 8'h41);
    repeat (6) @(posedge CLK_SYS);
    RST <= 1'b1;
    repeat (2) @(posedge CLK_SYS);
    RST <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(i[2:0], v);
      `CHK(v, 8'h00)
    end
    `CHK(IRQ, 1'b0)
    $display("test mid reset done");
    wr(ADDR_GATE, 8'h00);
    wcnt(16'h0000);
    wr(ADDR_CTRL, 8'h71);
    repeat (6) begin
      wr(ADDR_CNT_LO, 8'h00);
      repeat (3) @(posedge CLK_SYS);
    end
    wr(ADDR_CTRL, 8'h00);
    rdcnt(c);
    `CHK(c, 16'h0000)
    $display("test prescaler done");
    wr(ADDR_MASK, 8'h01);
    wcnt(16'hFFFE);
    wr(ADDR_CTRL, 8'h41);
    repeat (4) @(posedge CLK_SYS);
    wr(ADDR_CTRL, 8'h00);
    #1;
    `CHK(IRQ, 1'b1)
    rd(ADDR_STATUS, v);
    `CHK(v, 8'h01)
    wr(ADDR_MASK, 8'h00);
    #1;
    `CHK(IRQ, 1'b0)
    wr(ADDR_MASK, 8'h01);
    wr(ADDR_STATUS, 8'h01);
    #1;
    `CHK(IRQ, 1'b0)
    $display("test overflow done");
    // async in sleep, sync awake, sync in sleep
    for (int k = 0; k < 3; k++) begin
      wcnt(16'h0000);
      wr(ADDR_CTRL, k == 0 ? 8'h85 : 8'h81);
      SLEEP <= k != 1;
      r0 = ext_rises;
      ext_en <= 1'b1;
      repeat (60) @(posedge CLK_SYS);
      ext_en <= 1'b0;
      repeat (20) @(posedge CLK_SYS);
      r0 = ext_rises - r0 - 16'h0001;
      wr(ADDR_CTRL, 8'h00);
      SLEEP <= 1'b0;
      rdcnt(c);
      `CHK(c, k == 2 ? 16'h0000 : r0)
    end
    $display("test external done");
    wcnt(16'hFC00);
    SLEEP <= 1'b1;
    r0 = xtal_rises;
    wr(ADDR_CTRL, 8'h8D);
    for (int t = 0; t < 8000 && IRQ !== 1'b1; t++) @(posedge CLK_SYS);
    d = xtal_rises - r0;
    ok = d >= 16'h0400 && d <= 16'h0403;
    `CHK(ok, 1'b1)
    wr(ADDR_CTRL, 8'h00);
    SLEEP <= 1'b0;
    $display("test crystal done");
    final_report();
  end
endmodule : test_tcs_timer
